// ---- src/gcrc_top.sv ----
// Global configuration and reset control register bank with AXI4-Lite slave
//
// Contract
// RULE_01: A 16-bit writable profile code is loaded from the factory NVM image at startup, zero means none.
// RULE_02: Bit 7 of the startup settings picks the digital regulator level, 0 for 1.25V and 1 for 1.32V.
// RULE_03: A 3-bit field picks the crystal settle wait at startup, 1 ms by default.
// RULE_04: A 4-bit field, default 4, selects which stored user configuration startup reads.
// RULE_05: While lock bit 7 is 1 all NVM programming is blocked, and the bit resets to 0.
// RULE_06: Software can set the lock bit by writing 1 but never clear it.
// RULE_07: While the active-low common-set bit is 0 both input dividers are held set, reset value 1.
// RULE_08: A global output-enable bit, default 1, lets software control the clock outputs.
// RULE_09: Writing 1 to divider sync resyncs the output dividers and squelches outputs about 10 us.
// RULE_10: Writing 1 to re-initialize restarts startup at oscillator calibration, with divider sync.
// RULE_11: Software writes 0 before writing 1 again, since only a 0 to 1 change triggers.
// RULE_12: Bit 8 of the block resets holds the bias calibration in reset while 1.
// RULE_13: Bits 5 and 4 hold the negative and positive input activity watchers in reset.
// RULE_14: Bits 3, 2 and 1 hold the crystal, negative and positive signal-loss watchers in reset.
// RULE_15: Bit 0 holds the NVM interface logic in reset while 1.
// RULE_16: Reserved bits read as zero and writes to them are ignored.
`timescale 1ns/1ps
`default_nettype none
module gcrc_top
    import gcrc_pkg::*;
#(
    parameter int SETTLE_DIV = 1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Factory NVM image delivered at startup
    input  wire logic [15:0] nvm_profile_code_i,
    input  wire logic        nvm_loaded_i,
    output logic [3:0]       nvm_config_sel_o,
    output logic             nvm_load_req_o,
    input  wire logic        nvm_program_req_i,
    output logic             nvm_program_en_o,
    // Analog and block controls
    output logic             ldo_high_sel_o,
    output logic             input_div_hold_o,
    output logic             output_enable_o,
    output logic             output_squelch_o,
    output logic             osc_calibrating_o,
    output logic             bias_calibration_hold_o,
    output logic             activity_watch_neg_hold_o,
    output logic             activity_watch_pos_hold_o,
    output logic             signal_loss_crystal_hold_o,
    output logic             signal_loss_neg_hold_o,
    output logic             signal_loss_pos_hold_o,
    output logic             nvm_logic_hold_o
);
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Elaboration check: the sequencer cannot divide its settle count by zero
    if (SETTLE_DIV < 1) begin : g_bad_div
        $error("SETTLE_DIV must be at least 1");
    end

    logic [15:0] profile_reg;
    logic [7:0]  startup_reg;
    logic [7:0]  lock_reg;
    logic [7:0]  commands_reg;
    logic [15:0] blkrst_reg;
    logic        aw_held_reg;
    logic [7:0]  aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        sync_pulse_reg;
    logic        reinit_pulse_reg;
    logic        profile_loaded_reg;
    logic        do_write;
    logic        addr_ok_w;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [7:0]  cmd_next;
    logic        seq_busy;
    logic        load_req;

    // Write address and data are captured independently, in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    assign wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb;
    assign do_write = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
                   && (w_held_reg || (s_axi_wvalid && s_axi_wready));
    assign addr_ok_w = (wr_addr == GCRC_OFF_PROFILE) || (wr_addr == GCRC_OFF_STARTUP)
                    || (wr_addr == GCRC_OFF_LOCK) || (wr_addr == GCRC_OFF_COMMANDS)
                    || (wr_addr == GCRC_OFF_BLKRST) || (wr_addr == GCRC_OFF_STATUS);

    // Holding stages for the write channels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // Write response, one cycle after both halves are in
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Profile code: loaded once from NVM, software may overwrite later
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            profile_reg        <= GCRC_RST_PROFILE;
            profile_loaded_reg <= 1'b0;
        end else if (do_write && wr_addr == GCRC_OFF_PROFILE) begin
            // A write that meets the load wins, so the load must not retry later
            profile_loaded_reg <= profile_loaded_reg || nvm_loaded_i;
            if (wr_strb[0]) profile_reg[7:0]  <= wr_data[7:0];
            if (wr_strb[1]) profile_reg[15:8] <= wr_data[15:8];
        end else if (nvm_loaded_i && !profile_loaded_reg) begin // RULE_01
            profile_reg        <= nvm_profile_code_i;
            profile_loaded_reg <= 1'b1;
        end
    end

    // Startup settings, all eight bits writable
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            startup_reg <= GCRC_RST_STARTUP; // RULE_04
        end else if (do_write && wr_addr == GCRC_OFF_STARTUP && wr_strb[0]) begin
            startup_reg <= wr_data[7:0];
        end
    end

    // Lock is set-only; only power-on reset clears it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_reg <= GCRC_RST_LOCK;
        end else if (do_write && wr_addr == GCRC_OFF_LOCK && wr_strb[0]
                     && wr_data[GCRC_LOCK_BIT]) begin
            lock_reg[GCRC_LOCK_BIT] <= 1'b1; // RULE_06
        end
    end

    // Commands: reserved bits masked off, triggers on 0 to 1 edges only
    assign cmd_next = wr_data[7:0] & GCRC_MASK_COMMANDS; // RULE_16
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            commands_reg     <= GCRC_RST_COMMANDS;
            sync_pulse_reg   <= 1'b0;
            reinit_pulse_reg <= 1'b0;
        end else if (do_write && wr_addr == GCRC_OFF_COMMANDS && wr_strb[0]) begin
            commands_reg     <= cmd_next;
            sync_pulse_reg   <= cmd_next[GCRC_DIVSYNC_BIT] && !commands_reg[GCRC_DIVSYNC_BIT]; // RULE_11
            reinit_pulse_reg <= cmd_next[GCRC_REINIT_BIT] && !commands_reg[GCRC_REINIT_BIT]; // RULE_11
        end else begin
            sync_pulse_reg   <= 1'b0;
            reinit_pulse_reg <= 1'b0;
        end
    end

    // Block reset holds, reserved bits dropped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blkrst_reg <= GCRC_RST_BLKRST;
        end else if (do_write && wr_addr == GCRC_OFF_BLKRST) begin
            if (wr_strb[0]) blkrst_reg[7:0]  <= wr_data[7:0] & GCRC_MASK_BLKRST[7:0];
            if (wr_strb[1]) blkrst_reg[15:8] <= wr_data[15:8] & GCRC_MASK_BLKRST[15:8];
        end
    end

    // Read channel, data registered one cycle after the address
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                GCRC_OFF_PROFILE:  s_axi_rdata <= {16'h0000, profile_reg};
                GCRC_OFF_STARTUP:  s_axi_rdata <= {24'h000000, startup_reg};
                GCRC_OFF_LOCK:     s_axi_rdata <= {24'h000000, lock_reg};
                GCRC_OFF_COMMANDS: s_axi_rdata <= {24'h000000, commands_reg};
                GCRC_OFF_BLKRST:   s_axi_rdata <= {16'h0000, blkrst_reg};
                GCRC_OFF_STATUS:   s_axi_rdata <= {29'h00000000, load_req,
                                                   output_squelch_o, seq_busy};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    gcrc_startup_seq #(
        .SETTLE_DIV (SETTLE_DIV)
    ) u_seq (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .settle_sel_i  (startup_reg[GCRC_SETTLE_LSB +: 3]),
        .reinit_i      (reinit_pulse_reg),
        .sync_i        (sync_pulse_reg),
        .nvm_loaded_i  (nvm_loaded_i),
        .load_req_o    (load_req),
        .calibrating_o (osc_calibrating_o),
        .squelch_o     (output_squelch_o),
        .busy_o        (seq_busy)
    );

    // Control outputs from register bits; load request decoded from the sequencer state
    assign nvm_load_req_o             = load_req;
    assign nvm_config_sel_o           = startup_reg[GCRC_CFGSEL_LSB +: 4];        // RULE_04
    assign ldo_high_sel_o             = startup_reg[GCRC_LDO_SEL_BIT];             // RULE_02
    assign nvm_program_en_o           = nvm_program_req_i && !lock_reg[GCRC_LOCK_BIT]; // RULE_05
    assign input_div_hold_o           = !commands_reg[GCRC_DIVSET_N_BIT];          // RULE_07
    assign output_enable_o            = commands_reg[GCRC_OE_BIT];                 // RULE_08
    assign bias_calibration_hold_o    = blkrst_reg[GCRC_BIAS_BIT];                 // RULE_12
    assign activity_watch_neg_hold_o  = blkrst_reg[GCRC_ACT_NEG_BIT];              // RULE_13
    assign activity_watch_pos_hold_o  = blkrst_reg[GCRC_ACT_POS_BIT];              // RULE_13
    assign signal_loss_crystal_hold_o = blkrst_reg[GCRC_LOS_XTL_BIT];              // RULE_14
    assign signal_loss_neg_hold_o     = blkrst_reg[GCRC_LOS_NEG_BIT];              // RULE_14
    assign signal_loss_pos_hold_o     = blkrst_reg[GCRC_LOS_POS_BIT];              // RULE_14
    assign nvm_logic_hold_o           = blkrst_reg[GCRC_NVM_BIT];                  // RULE_15

    a_lock_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
        lock_reg[GCRC_LOCK_BIT] |=> lock_reg[GCRC_LOCK_BIT])
        else $error("lock bit cleared");
    a_lock_blocks: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_05
        lock_reg[GCRC_LOCK_BIT] |-> !nvm_program_en_o)
        else $error("programming allowed while locked");
    a_sync_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_11
        sync_pulse_reg |-> $rose(commands_reg[GCRC_DIVSYNC_BIT]))
        else $error("sync pulse without rising edge");
    a_reinit_edge: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_10
        reinit_pulse_reg |-> $rose(commands_reg[GCRC_REINIT_BIT]))
        else $error("reinit pulse without rising edge");
    a_div_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_07
        (do_write && wr_addr == GCRC_OFF_COMMANDS && wr_strb[0]) |=>
        input_div_hold_o == !$past(wr_data[GCRC_DIVSET_N_BIT]))
        else $error("divider hold mismatch");
    a_resv_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_16
        ((commands_reg & ~GCRC_MASK_COMMANDS) == 8'h00)
        && ((blkrst_reg & ~GCRC_MASK_BLKRST) == 16'h0000) && (lock_reg[6:0] == 7'h00))
        else $error("reserved bit set");
    a_bias_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_12
        (do_write && wr_addr == GCRC_OFF_BLKRST && wr_strb[1]) |=>
        bias_calibration_hold_o == $past(wr_data[GCRC_BIAS_BIT]))
        else $error("bias hold does not follow write");
    a_nvm_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_15
        (do_write && wr_addr == GCRC_OFF_BLKRST && wr_strb[0]) |=>
        nvm_logic_hold_o == $past(wr_data[GCRC_NVM_BIT]))
        else $error("nvm hold does not follow write");
endmodule
`default_nettype wire

// ---- src/gcrc_pkg.sv ----
// Package with register map, field positions, reset values and timing constants
package gcrc_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] GCRC_OFF_PROFILE  = 8'h00;
    localparam logic [7:0] GCRC_OFF_STARTUP  = 8'h04;
    localparam logic [7:0] GCRC_OFF_LOCK     = 8'h08;
    localparam logic [7:0] GCRC_OFF_COMMANDS = 8'h0C;
    localparam logic [7:0] GCRC_OFF_BLKRST   = 8'h10;
    localparam logic [7:0] GCRC_OFF_STATUS   = 8'h14;

    // Startup settings fields
    localparam int GCRC_LDO_SEL_BIT  = 7;
    localparam int GCRC_SETTLE_LSB   = 4;
    localparam int GCRC_CFGSEL_LSB   = 0;
    // Lock field
    localparam int GCRC_LOCK_BIT     = 7;
    // Command fields
    localparam int GCRC_DIVSET_N_BIT = 5;
    localparam int GCRC_OE_BIT       = 4;
    localparam int GCRC_DIVSYNC_BIT  = 1;
    localparam int GCRC_REINIT_BIT   = 0;
    // Block reset fields
    localparam int GCRC_BIAS_BIT     = 8;
    localparam int GCRC_ACT_NEG_BIT  = 5;
    localparam int GCRC_ACT_POS_BIT  = 4;
    localparam int GCRC_LOS_XTL_BIT  = 3;
    localparam int GCRC_LOS_NEG_BIT  = 2;
    localparam int GCRC_LOS_POS_BIT  = 1;
    localparam int GCRC_NVM_BIT      = 0;

    // Reset values
    localparam logic [15:0] GCRC_RST_PROFILE  = 16'h0000;
    localparam logic [7:0]  GCRC_RST_STARTUP  = 8'h04;
    localparam logic [7:0]  GCRC_RST_LOCK     = 8'h00;
    localparam logic [7:0]  GCRC_RST_COMMANDS = 8'h30;
    localparam logic [15:0] GCRC_RST_BLKRST   = 16'h0000;
    // Writable bit masks, everything else reads zero
    localparam logic [7:0]  GCRC_MASK_COMMANDS = 8'h33;
    localparam logic [15:0] GCRC_MASK_BLKRST   = 16'h013F;

    // Timing, clock 50 MHz
    localparam int GCRC_CLK_HZ      = 50_000_000;
    localparam int GCRC_SQUELCH_NS  = 10_000;
    localparam int GCRC_SQUELCH_CYC = GCRC_SQUELCH_NS / (1_000_000_000 / GCRC_CLK_HZ);
    localparam int GCRC_CAL_CYC     = 16;  // Oscillator calibration step length
    // Settle times in microseconds per code, code 7 reserved (falls back to 1 ms)
    localparam int GCRC_SETTLE_US [8] = '{1000, 2500, 5000, 7500, 10000, 500, 15000, 1000};
    localparam int GCRC_CYC_PER_US  = GCRC_CLK_HZ / 1_000_000;
endpackage

// ---- src/gcrc_startup_seq.sv ----
// Startup sequencer: crystal settle wait, oscillator calibration, divider sync squelch
`timescale 1ns/1ps
`default_nettype none
module gcrc_startup_seq
    import gcrc_pkg::*;
#(
    parameter int SETTLE_DIV = 1  // Divides settle counts so simulation can shorten them
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] settle_sel_i,
    input  wire logic       reinit_i,
    input  wire logic       sync_i,
    input  wire logic       nvm_loaded_i,
    output logic            load_req_o,
    output logic            calibrating_o,
    output logic            squelch_o,
    output logic            busy_o
);
    typedef enum logic [2:0] {S_SETTLE, S_LOAD, S_CAL, S_SYNC, S_RUN} gcrc_seq_type;

    // Elaboration check: a zero divider would make the settle count divide by zero
    if (SETTLE_DIV < 1) begin : g_bad_div
        $error("SETTLE_DIV must be at least 1");
    end

    gcrc_seq_type state_reg;
    logic [31:0]  cnt_reg;
    logic [31:0]  settle_cyc;

    assign settle_cyc = 32'(GCRC_SETTLE_US[settle_sel_i] * GCRC_CYC_PER_US / SETTLE_DIV);

    // Sequence state and shared counter (up in settle, down in calibration and sync); reinit restarts at calibration
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= S_SETTLE;
            cnt_reg   <= 32'h00000000;
        end else if (reinit_i) begin // RULE_10
            state_reg <= S_CAL;
            cnt_reg   <= 32'(GCRC_CAL_CYC);
        end else begin
            unique case (state_reg)
                S_SETTLE: begin // RULE_03
                    if (cnt_reg + 32'h1 >= settle_cyc) begin
                        state_reg <= S_LOAD;
                        cnt_reg   <= 32'h00000000;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                S_LOAD: begin
                    if (nvm_loaded_i) begin
                        state_reg <= S_CAL;
                        cnt_reg   <= 32'(GCRC_CAL_CYC);
                    end
                end
                S_CAL: begin
                    if (cnt_reg <= 32'h1) begin
                        state_reg <= S_SYNC;
                        cnt_reg   <= 32'(GCRC_SQUELCH_CYC);
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
                S_SYNC: begin // RULE_09
                    if (cnt_reg <= 32'h1) begin
                        state_reg <= S_RUN;
                        cnt_reg   <= 32'h00000000;
                    end else begin
                        cnt_reg <= cnt_reg - 32'h1;
                    end
                end
                S_RUN: begin
                    if (sync_i) begin
                        state_reg <= S_SYNC;
                        cnt_reg   <= 32'(GCRC_SQUELCH_CYC);
                    end
                end
            endcase
        end
    end

    // Status decodes
    assign load_req_o    = (state_reg == S_LOAD);
    assign calibrating_o = (state_reg == S_CAL);
    assign squelch_o     = (state_reg != S_RUN);
    assign busy_o        = (state_reg != S_RUN);

    a_sync_squelch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_09
        (state_reg == S_RUN && sync_i && !reinit_i) |=> squelch_o [*8])
        else $error("squelch missing after divider sync");
    a_reinit_cal: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_10
        reinit_i |=> calibrating_o)
        else $error("reinit did not restart calibration");
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking testbench for the global configuration and reset control bank
`timescale 1ns/1ps
`default_nettype none
module testbench import gcrc_pkg::*;;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} gcrc_row_type;
    logic        clk_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF, nvm_config_sel_o;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nvm_loaded_i = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [15:0] nvm_profile_code_i = 16'hA5C3;
    logic        nvm_program_req_i = 1'b1, nvm_load_req_o, nvm_program_en_o, ldo_high_sel_o;
    logic        input_div_hold_o, output_enable_o, output_squelch_o, osc_calibrating_o;
    logic        bias_calibration_hold_o, activity_watch_neg_hold_o, activity_watch_pos_hold_o;
    logic        signal_loss_crystal_hold_o, signal_loss_neg_hold_o, signal_loss_pos_hold_o;
    logic        nvm_logic_hold_o;
    int          mismatches = 0, comparisons = 0, n;
    // Written value beside the value that must read back
    gcrc_row_type rows [7] = '{
        '{GCRC_OFF_PROFILE, 32'h0000BEEF, 32'h0000BEEF},
        '{GCRC_OFF_STARTUP, 32'hFFFFFFFF, 32'h000000FF},
        '{GCRC_OFF_LOCK, 32'hFFFFFF7F, 32'h00000000},
        '{GCRC_OFF_LOCK, 32'h00000080, 32'h00000080},
        '{GCRC_OFF_LOCK, 32'h00000000, 32'h00000080},
        '{GCRC_OFF_BLKRST, 32'hFFFFFFFF, 32'h0000013F},
        '{GCRC_OFF_COMMANDS, 32'hFFFFFFCC, 32'h00000000}
    };

    gcrc_top #(.SETTLE_DIV(1000)) DUT (.clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nvm_profile_code_i,
        .nvm_loaded_i, .nvm_config_sel_o, .nvm_load_req_o, .nvm_program_req_i,
        .nvm_program_en_o, .ldo_high_sel_o, .input_div_hold_o, .output_enable_o,
        .output_squelch_o, .osc_calibrating_o, .bias_calibration_hold_o,
        .activity_watch_neg_hold_o, .activity_watch_pos_hold_o, .signal_loss_crystal_hold_o,
        .signal_loss_neg_hold_o, .signal_loss_pos_hold_o, .nvm_logic_hold_o);

    // Clock at 50 MHz
    always #10 clk_i = ~clk_i;

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Signals a wait can watch, by index
    function automatic logic pick(input int s);
        case (s)
            0: return nvm_load_req_o;
            1: return output_squelch_o;
            2: return s_axi_bvalid;
            3: return s_axi_rvalid;
            4: return osc_calibrating_o;
            default: return s_axi_arready;
        endcase
    endfunction

    // Bounded wait, sampled at the falling edge where levels are settled
    task automatic till(input int s, input logic v, input int lim, output int k);
        k = 0;
        @(negedge clk_i);
        while (pick(s) !== v) begin
            k++;
            if (k > lim) begin
                mismatches++;
                summarize();
            end
            @(negedge clk_i);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, ta, tw;
        int   k;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        k = 0;
        while (aw || w) begin
            @(negedge clk_i);
            ta = aw && s_axi_awready === 1'b1;
            tw = w && s_axi_wready === 1'b1;
            @(posedge clk_i);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                w = 1'b0;
            end
            k++;
            if (k > 50) begin
                mismatches++;
                summarize();
            end
        end
        till(2, 1'b1, 50, k);
        r = s_axi_bresp;
        @(posedge clk_i);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        till(5, 1'b1, 50, k);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b0;
        till(3, 1'b1, 50, k);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk_i);
        s_axi_rready <= 1'b0;
    endtask

    // Main sequence: reset, table of register accesses, then the awkward cases
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        till(0, 1'b1, 2000, n);
        @(posedge clk_i);
        nvm_loaded_i <= 1'b1;
        till(1, 1'b0, 5000, n);
        rd(GCRC_OFF_PROFILE, rv, rr);
        chk(rv, 32'h0000A5C3);
        rd(GCRC_OFF_STARTUP, rv, rr);
        chk(rv, 32'h00000004);
        rd(GCRC_OFF_LOCK, rv, rr);
        chk(rv, 32'h00000000);
        rd(GCRC_OFF_COMMANDS, rv, rr);
        chk(rv, 32'h00000030);
        rd(GCRC_OFF_BLKRST, rv, rr);
        chk(rv, 32'h00000000);
        chk({24'h000000, ldo_high_sel_o, output_enable_o, input_div_hold_o, nvm_program_en_o,
             nvm_config_sel_o}, 32'h00000054);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rr);
            rd(rows[i].a, rv, rr);
            chk(rv, rows[i].e);
        end
        chk({24'h000000, ldo_high_sel_o, output_enable_o, input_div_hold_o, nvm_program_en_o,
             nvm_config_sel_o}, 32'h000000AF);
        chk({25'h0000000, bias_calibration_hold_o, activity_watch_neg_hold_o,
             activity_watch_pos_hold_o, signal_loss_crystal_hold_o, signal_loss_neg_hold_o,
             signal_loss_pos_hold_o, nvm_logic_hold_o}, 32'h0000007F);
        $display("test registers done");
        // Unmapped place answers with a slave error and reads zero
        wr(8'h18, 32'hFFFFFFFF, rr);
        chk({30'h00000000, rr}, 32'h00000002);
        rd(8'h18, rv, rr);
        chk(rv, 32'h00000000);
        chk({30'h00000000, rr}, 32'h00000002);
        $display("test unmapped done");
        wr(GCRC_OFF_COMMANDS, 32'h00000030, rr);
        wr(GCRC_OFF_COMMANDS, 32'h00000032, rr);
        till(1, 1'b1, 20, n);
        till(1, 1'b0, 1000, n);
        chk(32'(n + 1), 32'(GCRC_SQUELCH_CYC));
        // A second 1 without a 0 between must not squelch again
        wr(GCRC_OFF_COMMANDS, 32'h00000032, rr);
        repeat (30) @(posedge clk_i);
        chk({31'h00000000, output_squelch_o}, 32'h00000000);
        wr(GCRC_OFF_COMMANDS, 32'h00000030, rr);
        wr(GCRC_OFF_COMMANDS, 32'h00000031, rr);
        till(4, 1'b1, 20, n);
        till(4, 1'b0, 100, n);
        chk(32'(n + 1), 32'(GCRC_CAL_CYC));
        chk({31'h00000000, output_squelch_o}, 32'h00000001);
        // Status shows the sequencer busy and squelching while it resyncs
        rd(GCRC_OFF_STATUS, rv, rr);
        chk(rv, 32'h00000003);
        till(1, 1'b0, 1000, n);
        $display("test commands done");
        // Only a reset returns the lock to 0; command defaults come back too
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(GCRC_OFF_LOCK, rv, rr);
        chk(rv, 32'h00000000);
        rd(GCRC_OFF_COMMANDS, rv, rr);
        chk(rv, 32'h00000030);
        $display("test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
